/* File: core/adpp_defs.svh */
// Named constants of the converter digital back end.
// Assumes a 25 MHz clk_sys that also carries the sampling strobe.
`ifndef ADPP_DEFS_SVH
`define ADPP_DEFS_SVH

`define ADPP_W 12
`define ADPP_CLK_MHZ 25
`define ADPP_BYP_LAT 4'ha
`define ADPP_PROC_LAT 4'hc
`define ADPP_MEM_BACK 4'h8
`define ADPP_MEM_AW 4
`define ADPP_GAIN_MAX 4'hc
`define ADPP_GAIN_FRAC 10
`define ADPP_TC_BASE 20
`define ADPP_TC_LAST 4'hb
`define ADPP_ACC_FRAC 32
`define ADPP_ACC_W 46
`define ADPP_POS_FS 12'h7ff
`define ADPP_NEG_FS 12'h800
`define ADPP_T_PDN_NS 100000
`define ADPP_T_SLEEP_NS 5000
`define ADPP_T_OBUF_NS 100
`define ADPP_T_SLOW_NS 1000
`define ADPP_CYC_UP(ns) (((ns) * `ADPP_CLK_MHZ + 999) / 1000)
`define ADPP_CYC_DN(ns) (((ns) * `ADPP_CLK_MHZ) / 1000)
`define ADPP_FMT_OB_BIT 1
`define ADPP_FMT_CMOS_A 2'h1
`define ADPP_FMT_CMOS_B 2'h2

`endif

/* File: core/adpp_pkg.sv */
// Types shared by the converter digital back end.
// Assumes adpp_defs.svh supplies the numeric constants.
package adpp_pkg;
  typedef enum logic [3:0] {
    PWR_OFF = 4'h1,
    PWR_SLEEP = 4'h2,
    PWR_WAKE = 4'h4,
    PWR_RUN = 4'h8
  } adpp_pwr_e;
endpackage

/* File: core/adpp_dly_mem.sv */
// Small circular memory that forms the fixed converter pipeline delay.
// Assumes one write and one registered read per enabled cycle.
`timescale 1ns/1ns
`default_nettype none
module adpp_dly_mem #(
  parameter int W = 12,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Access
  input wire logic en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  // The array has no reset; early reads are masked by the fill counter upstream.
  always_ff @(posedge clk_sys)
  begin
    if (en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= '0;
    end
    else if (en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: core/adpp_core.sv */
// Digital back end of a 12-bit converter: bypass and processing paths, power modes.
// Assumes samples arrive on clk_sys with a strobe; config bits come from a serial block.
// Notes on behaviour
// - Bypass mode sends raw samples out after ten sample strobes.
// - Processing mode adds pipeline stages, so latency exceeds the bypass path.
// - Reset selects bypass; controller sets bypass_path_off before digital functions.
// - Gain field selects 0 to 6 dB in half decibel steps.
// - Leaving bypass gives 0 dB gain until the gain field is written.
// - Gain shrinks full scale proportionally, 2 Vpp down to 1 Vpp.
// - With dc_fix_on, offset is estimated and subtracted from every sample.
// - Loop time constant codes 0 to 11 give 1M to 2G cycles; rest reserved.
// - dc_fix_hold stops estimation and keeps applying the last estimate.
// - Offset fix is off after reset; enabled only after leaving bypass.
// - Full power-down tri-states outputs; valid data returns after 100 us.
// - Core sleep powers down only the converter core; wake takes 5 us.
// - outputs_hiz or the enable pin tri-state outputs; recovery takes 100 ns.
// - Sampling slower than 1 MSPS puts the device in low power.
// - Output coding is two's complement or offset binary, by bit or pin.
// - Overdrive saturates the code at positive or negative full scale.
// - Each configuration transfer carries an 8-bit address and 8-bit data.
// - Enable pin low disables the data buffers, high enables them.
// - The four-level format pin selects coding and output interface type.
`timescale 1ns/1ns
`default_nettype none
`include "adpp_defs.svh"
module adpp_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Converter samples
  input wire logic sample_valid,
  input wire logic [`ADPP_W-1:0] sample_raw,
  output logic sample_ready,
  // Configuration bits
  input wire logic bypass_path_off,
  input wire logic gain_wr,
  input wire logic [7:0] gain_wr_data,
  input wire logic dc_fix_on,
  input wire logic [3:0] dc_loop_tc,
  input wire logic dc_fix_hold,
  input wire logic data_format_ob,
  input wire logic full_powerdown,
  input wire logic core_sleep,
  input wire logic outputs_hiz,
  // Mode pins
  input wire logic pin_config,
  input wire logic oe_pin,
  input wire logic [1:0] format_select_pin,
  // Output data
  output logic [`ADPP_W-1:0] data_out,
  output logic data_valid,
  input wire logic data_ready,
  output logic data_oe_n,
  output logic cmos_mode,
  // Power status
  output logic core_powered,
  output logic refs_powered,
  output logic low_power_state
);
  localparam logic [11:0] T_PDN = 12'(`ADPP_CYC_UP(`ADPP_T_PDN_NS));
  localparam logic [11:0] T_SLEEP = 12'(`ADPP_CYC_UP(`ADPP_T_SLEEP_NS));
  localparam logic [1:0] T_OBUF = 2'(`ADPP_CYC_UP(`ADPP_T_OBUF_NS));
  localparam logic [4:0] T_SLOW = 5'(`ADPP_CYC_DN(`ADPP_T_SLOW_NS));

  // Gain as Q1.10 of 10^(code/40).
  function automatic logic [11:0] gain_coef(input logic [3:0] code);
    case (code)
      4'h0: gain_coef = 12'h400;
      4'h1: gain_coef = 12'h43d;
      4'h2: gain_coef = 12'h47d;
      4'h3: gain_coef = 12'h4c1;
      4'h4: gain_coef = 12'h509;
      4'h5: gain_coef = 12'h556;
      4'h6: gain_coef = 12'h5a6;
      4'h7: gain_coef = 12'h5fc;
      4'h8: gain_coef = 12'h657;
      4'h9: gain_coef = 12'h6b7;
      4'ha: gain_coef = 12'h71d;
      4'hb: gain_coef = 12'h789;
      default: gain_coef = 12'h7fb;
    endcase
  endfunction

  function automatic logic [11:0] sat12(input logic signed [24:0] v);
    if (v > 25'sd2047)
    begin
      sat12 = `ADPP_POS_FS;
    end
    else if (v < -25'sd2048)
    begin
      sat12 = `ADPP_NEG_FS;
    end
    else
    begin
      sat12 = v[11:0];
    end
  endfunction

  // Pin synchronisers.
  logic oe_s1, oe_s2, pcfg_s1, pcfg_s2;
  logic [1:0] fmt_s1, fmt_s2;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_s1 <= 1'b0;
      oe_s2 <= 1'b0;
      pcfg_s1 <= 1'b0;
      pcfg_s2 <= 1'b0;
      fmt_s1 <= 2'h0;
      fmt_s2 <= 2'h0;
    end
    else
    begin
      oe_s1 <= oe_pin;
      oe_s2 <= oe_s1;
      pcfg_s1 <= pin_config;
      pcfg_s2 <= pcfg_s1;
      fmt_s1 <= format_select_pin;
      fmt_s2 <= fmt_s1;
    end
  end

  // Power state and wake timing.
  adpp_pkg::adpp_pwr_e pwr, next_pwr;
  logic [11:0] wake_cnt, next_wake_cnt;
  logic [1:0] obuf_cnt, next_obuf_cnt;
  logic [4:0] gap_cnt, next_gap_cnt;
  logic low_pwr, next_low_pwr;
  logic obuf_off;

  assign obuf_off = outputs_hiz || !oe_s2;

  always_comb
  begin
    next_pwr = pwr;
    next_wake_cnt = wake_cnt;
    case (pwr)
      adpp_pkg::PWR_OFF:
      begin
        if (!full_powerdown)
        begin
          next_pwr = adpp_pkg::PWR_WAKE;
          next_wake_cnt = T_PDN;
        end
      end
      adpp_pkg::PWR_SLEEP:
      begin
        if (full_powerdown)
        begin
          next_pwr = adpp_pkg::PWR_OFF;
        end
        else if (!core_sleep)
        begin
          next_pwr = adpp_pkg::PWR_WAKE;
          next_wake_cnt = T_SLEEP;
        end
      end
      adpp_pkg::PWR_WAKE:
      begin
        if (full_powerdown)
        begin
          next_pwr = adpp_pkg::PWR_OFF;
        end
        else if (core_sleep)
        begin
          next_pwr = adpp_pkg::PWR_SLEEP;
        end
        else if (wake_cnt <= 12'h001)
        begin
          next_pwr = adpp_pkg::PWR_RUN;
          next_wake_cnt = 12'h000;
        end
        else
        begin
          next_wake_cnt = wake_cnt - 12'h001;
        end
      end
      default:
      begin
        if (full_powerdown)
        begin
          next_pwr = adpp_pkg::PWR_OFF;
        end
        else if (core_sleep)
        begin
          next_pwr = adpp_pkg::PWR_SLEEP;
        end
      end
    endcase
    next_obuf_cnt = obuf_off ? T_OBUF : (obuf_cnt != 2'h0 ? obuf_cnt - 2'h1 : 2'h0);
    // Counts cycles since the last strobe; saturating keeps the flag steady.
    next_gap_cnt = sample_valid ? 5'h00 : (gap_cnt == T_SLOW ? gap_cnt : gap_cnt + 5'h01);
    next_low_pwr = (next_gap_cnt == T_SLOW);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr <= adpp_pkg::PWR_RUN;
      wake_cnt <= 12'h000;
      obuf_cnt <= 2'h0;
      gap_cnt <= 5'h00;
      low_pwr <= 1'b0;
    end
    else
    begin
      pwr <= next_pwr;
      wake_cnt <= next_wake_cnt;
      obuf_cnt <= next_obuf_cnt;
      gap_cnt <= next_gap_cnt;
      low_pwr <= next_low_pwr;
    end
  end

  // Sample pipeline: fixed delay memory, then gain and offset stages.
  logic adv, run;
  logic [`ADPP_MEM_AW-1:0] wp, next_wp;
  logic [`ADPP_W-1:0] raw_d;
  logic [3:0] fill, next_fill;
  logic [3:0] gain_code, next_gain_code;
  logic [11:0] g_word, next_g_word;
  logic [11:0] c_word, next_c_word;
  logic [11:0] b_word, next_b_word;
  logic signed [`ADPP_ACC_W-1:0] acc, next_acc;
  logic signed [11:0] dc_est;
  logic offset_bin;
  logic buf_ready;

  assign run = (pwr == adpp_pkg::PWR_RUN);
  // The converter cannot pause, so a full buffer drops the strobe; sample_ready shows it.
  assign adv = sample_valid && buf_ready && run;
  assign dc_est = 12'(acc >>> `ADPP_ACC_FRAC);

  adpp_dly_mem #(.W(`ADPP_W), .AW(`ADPP_MEM_AW)) u_dly (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .en(adv),
    .wr_addr(wp),
    .wr_data(sample_raw),
    .rd_addr(wp - `ADPP_MEM_BACK),
    .rd_data(raw_d)
  );

  always_comb
  begin
    logic [11:0] coef;
    logic signed [23:0] prod;
    logic signed [`ADPP_ACC_W-1:0] err;
    coef = gain_coef(gain_code);
    // Gain works one stage after the bypass tap, so processing adds two stages in all.
    prod = $signed(b_word) * $signed({1'b0, coef[10:0]});
    err = ($signed(`ADPP_ACC_W'($signed(g_word))) <<< `ADPP_ACC_FRAC) - acc;
    next_wp = adv ? wp + 4'(1) : wp;
    next_fill = (adv && fill != `ADPP_PROC_LAT) ? fill + 4'h1 : fill;
    // Gain updates only on a write; leaving bypass keeps the 0 dB reset value.
    next_gain_code = gain_code;
    if (gain_wr && gain_wr_data[3:0] <= `ADPP_GAIN_MAX)
    begin
      next_gain_code = gain_wr_data[3:0];
    end
    next_b_word = adv ? raw_d : b_word;
    next_g_word = adv ? sat12(25'(prod >>> `ADPP_GAIN_FRAC)) : g_word;
    next_c_word = c_word;
    if (adv)
    begin
      next_c_word = sat12(25'($signed(g_word)) - 25'(dc_est));
    end
    next_acc = acc;
    if (!dc_fix_on || !bypass_path_off)
    begin
      next_acc = '0;
    end
    // Words ahead of a full pipeline are stale, so they must not feed the estimate.
    else if (adv && fill == `ADPP_PROC_LAT && !dc_fix_hold && dc_loop_tc <= `ADPP_TC_LAST)
    begin
      next_acc = acc + (err >>> (`ADPP_TC_BASE + 32'(dc_loop_tc)));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp <= '0;
      fill <= 4'h0;
      gain_code <= 4'h0;
      b_word <= '0;
      g_word <= '0;
      c_word <= '0;
      acc <= '0;
    end
    else
    begin
      wp <= next_wp;
      fill <= next_fill;
      gain_code <= next_gain_code;
      b_word <= next_b_word;
      g_word <= next_g_word;
      c_word <= next_c_word;
      acc <= next_acc;
    end
  end

  // Output selection, coding and two-entry buffer.
  logic push, pop;
  logic [11:0] push_word, sel_word;
  logic [11:0] e0, e1, next_e0, next_e1;
  logic [1:0] cnt, next_cnt;
  logic oe_n_d, cmos_d;

  assign offset_bin = pcfg_s2 ? fmt_s2[`ADPP_FMT_OB_BIT] : data_format_ob;
  assign sel_word = bypass_path_off ? c_word : b_word;
  assign push_word = offset_bin ? {~sel_word[11], sel_word[10:0]} : sel_word;
  assign push = adv && (bypass_path_off ? fill == `ADPP_PROC_LAT : fill >= `ADPP_BYP_LAT);
  assign pop = data_valid && data_ready;
  assign buf_ready = sample_ready;

  always_comb
  begin
    next_e0 = e0;
    next_e1 = e1;
    next_cnt = cnt;
    if (pop)
    begin
      next_e0 = e1;
      next_cnt = next_cnt - 2'h1;
    end
    if (push)
    begin
      if (next_cnt == 2'h0)
      begin
        next_e0 = push_word;
      end
      else
      begin
        next_e1 = push_word;
      end
      next_cnt = next_cnt + 2'h1;
    end
    // The next power state releases the buffers on the same edge that power goes down.
    oe_n_d = next_pwr != adpp_pkg::PWR_RUN || obuf_off || obuf_cnt != 2'h0;
    cmos_d = pcfg_s2 && (fmt_s2 == `ADPP_FMT_CMOS_A || fmt_s2 == `ADPP_FMT_CMOS_B);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      e0 <= '0;
      e1 <= '0;
      cnt <= 2'h0;
      data_out <= '0;
      data_valid <= 1'b0;
      sample_ready <= 1'b0;
      data_oe_n <= 1'b1;
      cmos_mode <= 1'b0;
      core_powered <= 1'b0;
      refs_powered <= 1'b0;
      low_power_state <= 1'b0;
    end
    else
    begin
      e0 <= next_e0;
      e1 <= next_e1;
      cnt <= next_cnt;
      data_out <= next_e0;
      data_valid <= next_cnt != 2'h0;
      sample_ready <= next_cnt != 2'h2;
      data_oe_n <= oe_n_d;
      cmos_mode <= cmos_d;
      core_powered <= next_pwr == adpp_pkg::PWR_RUN || next_pwr == adpp_pkg::PWR_WAKE;
      refs_powered <= next_pwr != adpp_pkg::PWR_OFF;
      low_power_state <= low_pwr;
    end
  end
endmodule
`default_nettype wire

/* File: verif/adpp_rx.sv */
// Receiving logic model that takes output words from the back end.
// Assumes the bench seeds $urandom and picks the stall mode at run time.
`timescale 1ns/1ns
`default_nettype none
`include "adpp_defs.svh"
module adpp_rx (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Output stream
  input wire logic [`ADPP_W-1:0] data_out,
  input wire logic data_valid,
  output logic data_ready,
  // Mode: 0 always ready, 1 random stalls, 2 never ready
  input wire logic [1:0] stall
);
  logic [`ADPP_W-1:0] got[$];

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      data_ready <= 1'b0;
    else
    begin
      if (data_valid && data_ready)
        got.push_back(data_out);
      data_ready <= (stall == 2'h0) || (stall == 2'h1 && $urandom_range(1, 0) == 1);
    end
  end
endmodule
`default_nettype wire

/* File: verif/adpp_core_checker.sv */
// Concurrent checks on the ports of the converter back end.
// Assumes mode pins are held still while reset is applied.
`timescale 1ns/1ns
`default_nettype none
`include "adpp_defs.svh"
module adpp_core_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Inputs
  input wire logic sample_valid,
  input wire logic full_powerdown,
  input wire logic core_sleep,
  input wire logic outputs_hiz,
  input wire logic pin_config,
  input wire logic oe_pin,
  input wire logic [1:0] format_select_pin,
  input wire logic data_ready,
  // Outputs
  input wire logic [`ADPP_W-1:0] data_out,
  input wire logic data_valid,
  input wire logic data_oe_n,
  input wire logic cmos_mode,
  input wire logic core_powered,
  input wire logic refs_powered,
  input wire logic low_power_state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Saturating, so a long idle gap never wraps back under the threshold.
  logic [5:0] idle;
  logic [5:0] next_idle;
  always_comb
  begin
    next_idle = idle;
    if (sample_valid)
      next_idle = 6'h00;
    else if (idle != 6'h3f)
      next_idle = idle + 6'h01;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      idle <= 6'h00;
    else
      idle <= next_idle;

  AST_OFF_TRISTATE: assert property (full_powerdown |=> data_oe_n && !refs_powered)
    else $error("outputs or references alive in full power-down");
  AST_DRIVE_CAUSE: assert property (!data_oe_n |-> !$past(outputs_hiz) && !$past(full_powerdown))
    else $error("outputs driven while disabled");
  AST_SLEEP_REFS: assert property ((core_sleep && !full_powerdown) [*2] |-> !core_powered && refs_powered)
    else $error("core sleep power status wrong");
  AST_HIZ_BIT: assert property (outputs_hiz |=> data_oe_n)
    else $error("outputs not released by outputs_hiz");
  AST_HIZ_RECOVER: assert property ($fell(outputs_hiz) |-> data_oe_n [*2])
    else $error("outputs returned without recovery time");
  AST_OE_PIN: assert property (!oe_pin [*4] |-> data_oe_n)
    else $error("outputs driven with enable pin low");
  AST_LOW_POWER: assert property (idle >= 6'h1c |-> low_power_state)
    else $error("no low power state after idle gap");
  AST_AWAKE: assert property (sample_valid [*2] |=> !low_power_state)
    else $error("low power state while sampling");
  AST_CMOS_PIN: assert property (cmos_mode |-> $past(pin_config, 3) && ($past(format_select_pin, 3) inside {2'h1, 2'h2}))
    else $error("cmos mode not selected by pin");
  AST_STALL_HOLD: assert property (data_valid && !data_ready |=> data_valid && $stable(data_out))
    else $error("output word lost during stall");
  COV_STALL: cover property (data_valid && !data_ready);
  COV_OFF: cover property (full_powerdown ##1 data_oe_n);
  COV_LOW: cover property (low_power_state);
endmodule
bind adpp_core adpp_core_checker chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .sample_valid(sample_valid), .full_powerdown(full_powerdown), .core_sleep(core_sleep),
  .outputs_hiz(outputs_hiz), .pin_config(pin_config), .oe_pin(oe_pin),
  .format_select_pin(format_select_pin), .data_ready(data_ready), .data_out(data_out),
  .data_valid(data_valid), .data_oe_n(data_oe_n), .cmos_mode(cmos_mode),
  .core_powered(core_powered), .refs_powered(refs_powered), .low_power_state(low_power_state));
`default_nettype wire

/* File: verif/adpp_core_tb.sv */
// Self-checking bench for the converter back end with a receiving model.
// Assumes adpp_core, adpp_rx and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`include "adpp_defs.svh"
module adpp_core_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, sample_valid = 1'b0, gain_wr = 1'b0;
  logic bypass_path_off = 1'b0, dc_fix_on = 1'b0, dc_fix_hold = 1'b0, data_format_ob = 1'b0;
  logic full_powerdown = 1'b0, core_sleep = 1'b0, outputs_hiz = 1'b0;
  logic pin_config = 1'b0, oe_pin = 1'b1;
  logic [1:0] format_select_pin = 2'h0, stall = 2'h0;
  logic [3:0] dc_loop_tc = 4'h0;
  logic [7:0] gain_wr_data = 8'h00;
  logic [11:0] sample_raw = 12'h000, data_out;
  logic sample_ready, data_valid, data_ready, data_oe_n, cmos_mode;
  logic core_powered, refs_powered, low_power_state;
  logic [11:0] tx[$], ex[$];
  logic [11:0] hot[5] = '{12'h7ff, 12'h800, 12'h500, 12'hb00, 12'h000};
  logic [11:0] sat[5] = '{12'h7ff, 12'h800, 12'h7ff, 12'h800, 12'h000};
  int n_errors = 0, comparisons = 0, cyc = 0;

  always #20 clk_sys = ~clk_sys;

  adpp_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .sample_valid(sample_valid),
    .sample_raw(sample_raw), .sample_ready(sample_ready), .bypass_path_off(bypass_path_off),
    .gain_wr(gain_wr), .gain_wr_data(gain_wr_data), .dc_fix_on(dc_fix_on),
    .dc_loop_tc(dc_loop_tc), .dc_fix_hold(dc_fix_hold), .data_format_ob(data_format_ob),
    .full_powerdown(full_powerdown), .core_sleep(core_sleep), .outputs_hiz(outputs_hiz),
    .pin_config(pin_config), .oe_pin(oe_pin), .format_select_pin(format_select_pin),
    .data_out(data_out), .data_valid(data_valid), .data_ready(data_ready),
    .data_oe_n(data_oe_n), .cmos_mode(cmos_mode), .core_powered(core_powered),
    .refs_powered(refs_powered), .low_power_state(low_power_state));
  adpp_rx rx (.clk_sys(clk_sys), .rst_n(rst_n), .data_out(data_out),
    .data_valid(data_valid), .data_ready(data_ready), .stall(stall));

  task automatic chk(input logic [11:0] seen, input logic [11:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic restart();
    rst_n = 1'b0;
    tick(5);
    rst_n = 1'b1;
    rx.got.delete();
    tx.delete();
    ex.delete();
  endtask

  function automatic logic [11:0] code_of(input logic [11:0] s, input logic ob);
    return ob ? {~s[11], s[10:0]} : s;
  endfunction

  task automatic fill(input logic ob, input int n);
    logic [11:0] s;
    for (int i = 0; i < n; i++)
    begin
      s = 12'($urandom);
      tx.push_back(s);
      ex.push_back(code_of(s, ob));
    end
  endtask

  // The last lat words stay inside the pipeline, so only the rest come out.
  task automatic run(input string name, input int lat);
    int k;
    int w;
    k = 0;
    w = 0;
    while (k < tx.size() && w < 3000)
    begin
      if (w == 200 && stall == 2'h2)
      begin
        chk(sample_ready, 1'b0);
        stall = 2'h1;
      end
      sample_valid = sample_ready;
      sample_raw = tx[k];
      if (sample_ready)
        k++;
      w++;
      tick(1);
    end
    sample_valid = 1'b0;
    tick(80);
    chk(12'(rx.got.size()), 12'(tx.size() - lat));
    for (int i = 0; i < rx.got.size() && i < ex.size(); i++)
      chk(rx.got[i], ex[i]);
    $display("test %s done", name);
  endtask

  task automatic gain_run(input logic on, input string name);
    bypass_path_off = on;
    restart();
    gain_wr = 1'b1;
    gain_wr_data = 8'h0c;
    tick(1);
    gain_wr = 1'b0;
    for (int i = 0; i < 17; i++)
      tx.push_back(i < 5 ? hot[i] : 12'h000);
    for (int i = 0; i < 5; i++)
      ex.push_back(on ? sat[i] : hot[i]);
    run(name, on ? 12 : 10);
  endtask

  initial
  begin
    void'($urandom(32'h1580));
    restart();
    stall = 2'h2;
    fill(1'b0, 40);
    run("bypass_stall", 10);
    data_format_ob = 1'b1;
    restart();
    fill(1'b1, 40);
    run("bypass_offset_binary", 10);
    pin_config = 1'b1;
    for (int f = 0; f < 4; f++)
    begin
      format_select_pin = 2'(f);
      data_format_ob = ~format_select_pin[1];
      restart();
      fill(format_select_pin[1], 20);
      run("format_pin", 10);
      chk(cmos_mode, format_select_pin[0] ^ format_select_pin[1]);
    end
    pin_config = 1'b0;
    data_format_ob = 1'b0;
    gain_run(1'b0, "gain_in_bypass");
    bypass_path_off = 1'b1;
    restart();
    // A reserved gain code must be ignored, leaving the 0 dB setting.
    gain_wr = 1'b1;
    gain_wr_data = 8'h0d;
    tick(1);
    gain_wr = 1'b0;
    fill(1'b0, 40);
    run("processing_unity", 12);
    gain_run(1'b1, "gain_saturate");
    // A constant full-scale input gives a positive estimate that pulls the output down.
    stall = 2'h0;
    dc_fix_on = 1'b1;
    restart();
    for (int i = 0; i < 2000; i++)
      tx.push_back(12'h7ff);
    run("offset_track", 12);
    chk(12'(rx.got[$] < 12'h7ff), 12'h001);
    dc_fix_hold = 1'b1;
    rx.got.delete();
    sample_valid = 1'b1;
    tick(700);
    sample_valid = 1'b0;
    tick(20);
    chk(12'(rx.got.size()), 12'h2bc);
    chk(rx.got[$], rx.got[0]);
    chk(12'(rx.got[0] < 12'h7ff), 12'h001);
    $display("test offset_freeze done");
    dc_fix_on = 1'b0;
    dc_fix_hold = 1'b0;
    bypass_path_off = 1'b0;
    stall = 2'h0;
    restart();
    tick(30);
    chk(low_power_state, 1'b1);
    sample_valid = 1'b1;
    tick(5);
    chk(low_power_state, 1'b0);
    sample_valid = 1'b0;
    outputs_hiz = 1'b1;
    tick(2);
    chk(data_oe_n, 1'b1);
    outputs_hiz = 1'b0;
    tick(2);
    chk(data_oe_n, 1'b1);
    tick(4);
    chk(data_oe_n, 1'b0);
    oe_pin = 1'b0;
    tick(5);
    chk(data_oe_n, 1'b1);
    oe_pin = 1'b1;
    core_sleep = 1'b1;
    tick(6);
    chk({core_powered, refs_powered}, 2'h1);
    core_sleep = 1'b0;
    tick(100);
    chk({core_powered, data_oe_n}, 2'h3);
    tick(30);
    chk({core_powered, data_oe_n}, 2'h2);
    full_powerdown = 1'b1;
    tick(3);
    chk({data_oe_n, core_powered, refs_powered}, 3'h4);
    full_powerdown = 1'b0;
    tick(2400);
    chk({data_oe_n, core_powered, refs_powered}, 3'h7);
    tick(110);
    chk({data_oe_n, core_powered, refs_powered}, 3'h3);
    $display("test power_modes done");
    end_of_test();
  end
endmodule
`default_nettype wire
